// ---- rtl/half_duplex_carrier_control.sv ----
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module half_duplex_carrier_control
  import hdx_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // System
  input wire logic core_clk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Transmit side, core clock
  input wire logic tx_req_i,
  output logic tx_busy_o,
  // Link side
  input wire logic link_clk_i,
  input wire logic link_reset_i,
  input wire logic tx_done_i,
  output logic tx_go_o,
  output logic dcd_o
);

  // Core-side state
  ctrl_t ctrl;
  timers_t tmr;
  car_state_t state;
  car_state_t next_state;
  logic [31:0] tick_cnt;
  logic ms_tick;
  logic [15:0] dly_cnt;
  logic dly_run;
  logic dly_zero_seen;
  logic dly_expired;
  logic tx_active;
  logic dcd_level;
  logic go_level;

  // Bus data phase bookkeeping
  logic wr_pend;
  logic [11:0] wr_addr;

  // Link crossings: done travels as a toggle, grant as a level
  logic done_tgl_l;
  logic [1:0] go_sync;
  logic [2:0] done_sync;
  wire logic done_evt = done_sync[2] ^ done_sync[1];

  function automatic logic [31:0] timer_word(input logic [15:0] v);
    timer_word = {16'h0, v};
  endfunction

  function automatic logic [31:0] read_mux(input logic [11:0] a, input ctrl_t c, input timers_t t,
                                           input logic dcd, input logic busy, input logic [1:0] st);
    case (a)
      OFF_CTRL: read_mux = {29'h0, c};
      OFF_STATUS: read_mux = {28'h0, st, busy, dcd};
      OFF_CTS_DELAY: read_mux = timer_word(t.cts_delay);
      OFF_CTS_DROP_TMO: read_mux = timer_word(t.cts_drop_tmo);
      OFF_DCD_DROP: read_mux = timer_word(t.dcd_drop);
      OFF_DCD_TXSTART: read_mux = timer_word(t.dcd_txstart);
      OFF_RTS_DROP: read_mux = timer_word(t.rts_drop);
      OFF_RTS_TMO: read_mux = timer_word(t.rts_tmo);
      OFF_TX_DELAY: read_mux = timer_word(t.tx_delay);
      default: read_mux = 32'h0;
    endcase
  endfunction

  // Shared by the tick counter and its pulse so both wrap on the same count
  function automatic logic at_limit(input logic [31:0] cnt, input int lim);
    at_limit = (cnt == 32'(lim - 1));
  endfunction

  // Bus decode; only whole-word writes land
  wire logic word_ok = (hsize_i == {1'b0, HSIZE_WORD});
  wire logic bus_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  wire logic wr_take = bus_take && hwrite_i && word_ok;
  wire logic rd_take = bus_take && !hwrite_i;

  // Sequencer decode
  wire logic tick_wrap = at_limit(tick_cnt, TICK_CYC);
  wire logic half_dce = ctrl.half && ctrl.dce;
  wire logic ctl_mode = half_dce && ctrl.ctl_carrier;
  wire logic cnt_zero = (dly_cnt == 16'h0);
  wire logic load_start = (state == st_idle) && tx_req_i && ctl_mode;
  wire logic load_drop = (state == st_send) && done_evt;
  wire logic dly_load = load_start || load_drop;
  wire logic [15:0] dly_init = load_start ? tmr.dcd_txstart : tmr.dcd_drop;
  wire logic seq_dcd = (state != st_idle);
  wire logic seq_go = (state == st_send);

  // Outside controlled carrier the carrier stays up and grants follow requests
  assign dcd_level = ctl_mode ? seq_dcd : 1'b1;
  assign go_level = ctl_mode ? seq_go : tx_req_i;
  assign dly_expired = dly_zero_seen;
  assign tx_active = seq_dcd;
  assign tx_busy_o = tx_active;
  assign tx_go_o = go_sync[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // Write data follows a cycle behind its address
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_pend <= 1'b0;
    end else begin
      wr_pend <= wr_take;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_addr <= 12'h000;
    end else if (bus_take) begin
      wr_addr <= haddr_i[11:0];
    end
  end

  // Unmapped writes are dropped
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl <= ctrl_t'(CTRL_RESET);
    end else if (wr_pend && (wr_addr == OFF_CTRL)) begin
      ctrl <= ctrl_t'(hwdata_i[2:0]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tmr <= '{DEF_CTS_DELAY, DEF_CTS_DROP_TMO, DEF_DCD_DROP, DEF_DCD_TXSTART,
               DEF_RTS_DROP, DEF_RTS_TMO, DEF_TX_DELAY};
    end else if (wr_pend) begin
      case (wr_addr)
        OFF_CTS_DELAY: tmr.cts_delay <= hwdata_i[15:0];
        OFF_CTS_DROP_TMO: tmr.cts_drop_tmo <= hwdata_i[15:0];
        OFF_DCD_DROP: tmr.dcd_drop <= hwdata_i[15:0];
        OFF_DCD_TXSTART: tmr.dcd_txstart <= hwdata_i[15:0];
        OFF_RTS_DROP: tmr.rts_drop <= hwdata_i[15:0];
        OFF_RTS_TMO: tmr.rts_tmo <= hwdata_i[15:0];
        OFF_TX_DELAY: tmr.tx_delay <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Read data is taken in the address phase so it stands during the data phase
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0;
    end else if (rd_take) begin
      hrdata_o <= read_mux(haddr_i[11:0], ctrl, tmr, dcd_level, tx_active, 2'(state));
    end
  end

  // Shared millisecond tick
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // Loads are not aligned to the tick, so a delay may run up to one tick short
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= tick_wrap;
    end
  end

  // Only the second stage feeds logic; the first may be metastable
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      go_sync <= 2'h0;
    end else begin
      go_sync <= {go_sync[0], go_level};
    end
  end

  // A toggle survives sampling in the other domain where a short pulse could be missed
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      done_tgl_l <= 1'b0;
    end else if (tx_done_i && go_sync[1]) begin
      done_tgl_l <= ~done_tgl_l;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      done_sync <= 3'h0;
    end else begin
      done_sync <= {done_sync[1:0], done_tgl_l};
    end
  end

  // Delay down-counter
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dly_cnt <= 16'h0;
    end else if (dly_load) begin
      dly_cnt <= dly_init;
    end else if (dly_run && !cnt_zero && ms_tick) begin
      dly_cnt <= dly_cnt - 16'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dly_run <= 1'b0;
    end else if (dly_load) begin
      dly_run <= 1'b1;
    end else if (dly_run && cnt_zero) begin
      dly_run <= 1'b0;
    end
  end

  // Expiry is flagged for one cycle, the cycle after the count reached zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dly_zero_seen <= 1'b0;
    end else if (dly_load) begin
      dly_zero_seen <= 1'b0;
    end else begin
      dly_zero_seen <= dly_run && cnt_zero;
    end
  end

  // Leaving controlled carrier abandons the sequence so busy cannot stick
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (load_start) begin
          next_state = st_start;
        end
      end
      st_start: begin
        if (!ctl_mode) begin
          next_state = st_idle;
        end else if (dly_expired) begin
          next_state = st_send;
        end
      end
      st_send: begin
        if (!ctl_mode) begin
          next_state = st_idle;
        end else if (done_evt) begin
          next_state = st_drop;
        end
      end
      st_drop: begin
        if (!ctl_mode) begin
          next_state = st_idle;
        end else if (dly_expired) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // DCD out registered in core domain
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dcd_o <= 1'b1;
    end else begin
      dcd_o <= dcd_level;
    end
  end

endmodule

// ---- pkg/hdx_pkg.sv ----
package hdx_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CTS_DELAY = 12'h008;
  localparam logic [11:0] OFF_CTS_DROP_TMO = 12'h00c;
  localparam logic [11:0] OFF_DCD_DROP = 12'h010;
  localparam logic [11:0] OFF_DCD_TXSTART = 12'h014;
  localparam logic [11:0] OFF_RTS_DROP = 12'h018;
  localparam logic [11:0] OFF_RTS_TMO = 12'h01c;
  localparam logic [11:0] OFF_TX_DELAY = 12'h020;
  // Control fields
  localparam int CTRL_HALF_BIT = 0;
  localparam int CTRL_CTLCAR_BIT = 1;
  localparam int CTRL_DCE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  // Timer defaults in ms
  localparam logic [15:0] DEF_CTS_DELAY = 16'h0000;
  localparam logic [15:0] DEF_CTS_DROP_TMO = 16'h00fa;
  localparam logic [15:0] DEF_DCD_DROP = 16'h0064;
  localparam logic [15:0] DEF_DCD_TXSTART = 16'h0064;
  localparam logic [15:0] DEF_RTS_DROP = 16'h0003;
  localparam logic [15:0] DEF_RTS_TMO = 16'h0003;
  localparam logic [15:0] DEF_TX_DELAY = 16'h0000;
  // Tick period
  localparam int CLK_HZ = 200000000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HSIZE_WORD = 2'h2;

  typedef enum {st_idle, st_start, st_send, st_drop} car_state_t;

  typedef struct packed {
    logic [15:0] cts_delay;
    logic [15:0] cts_drop_tmo;
    logic [15:0] dcd_drop;
    logic [15:0] dcd_txstart;
    logic [15:0] rts_drop;
    logic [15:0] rts_tmo;
    logic [15:0] tx_delay;
  } timers_t;

  typedef struct packed {
    logic dce;
    logic ctl_carrier;
    logic half;
  } ctrl_t;
endpackage

// ---- tb/hdx_monitor.sv ----
`timescale 1ns/1ps
module hdx_monitor
  import hdx_pkg::*;
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic tx_req_i,
  input wire logic tx_busy_o,
  input wire logic link_clk_i,
  input wire logic link_reset_i,
  input wire logic tx_go_o,
  input wire logic dcd_o
);
  wire logic rd_req = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_launch;
    $rose(tx_busy_o);
  endsequence
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not zero-wait okay");
  a_unmapped_zero: assert property (rd_req && haddr_i == 32'h24 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!rd_req |=> $stable(hrdata_o))
    else $error("read data moved without read");
  a_busy_needs_req: assert property (s_launch |-> $past(tx_req_i))
    else $error("sequencer left idle without request");
  a_launch_dcd: assert property (s_launch |=> dcd_o)
    else $error("carrier not raised after start");
  a_busy_dcd: assert property (tx_busy_o && $past(tx_busy_o) |-> dcd_o)
    else $error("carrier low while sequencing");
  a_dcd_fall_idle: assert property ($fell(dcd_o) |-> !tx_busy_o && !$past(tx_busy_o))
    else $error("carrier dropped while busy");
  a_go_with_dcd: assert property (@(posedge link_clk_i) disable iff (link_reset_i) $rose(tx_go_o) |-> dcd_o)
    else $error("send granted without carrier");
endmodule
bind half_duplex_carrier_control hdx_monitor mon_u (.*);

// ---- tb/dte_model.sv ----
`timescale 1ns/1ps
module dte_model #(
  parameter int SEND_CYC = 5
) (
  // Link
  input wire logic link_clk_i,
  input wire logic link_reset_i,
  input wire logic tx_go_i,
  output logic tx_done_o
);
  int cnt;
  // One done pulse per grant; later cycles of the same grant stay quiet
  always @(posedge link_clk_i) begin
    if (link_reset_i || !tx_go_i) begin
      cnt <= 0;
      tx_done_o <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      tx_done_o <= (cnt == SEND_CYC);
    end
  end
endmodule

// ---- tb/half_duplex_carrier_control_test.sv ----
`timescale 1ns/1ps
module half_duplex_carrier_control_test;
  import hdx_pkg::*;
  localparam int TCK = 10;
  logic clk = 0, rst = 1, lclk = 0, lrst = 1, req = 0, hwr = 0;
  logic [1:0] htr = 2'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, d;
  wire logic [31:0] hrd;
  wire logic rdy, resp, busy, go, done, dcd;
  int err_total = 0, total_checks = 0, cyc = 0, n;
  logic [15:0] defs [7] = '{DEF_CTS_DELAY, DEF_CTS_DROP_TMO, DEF_DCD_DROP, DEF_DCD_TXSTART,
    DEF_RTS_DROP, DEF_RTS_TMO, DEF_TX_DELAY};
  always #2.5 clk = ~clk;
  always #6 lclk = ~lclk;
  half_duplex_carrier_control #(.TICK_CYC(TCK)) dut_u (.core_clk_i(clk), .reset_i(rst), .hsel_i(1'b1),
    .haddr_i(ha), .htrans_i(htr), .hwrite_i(hwr), .hsize_i({1'b0, HSIZE_WORD}), .hwdata_i(hwd),
    .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(resp), .tx_req_i(req), .tx_busy_o(busy),
    .link_clk_i(lclk), .link_reset_i(lrst), .tx_done_i(done), .tx_go_o(go), .dcd_o(dcd));
  dte_model #(.SEND_CYC(5)) dte_u (.link_clk_i(lclk), .link_reset_i(lrst), .tx_go_i(go), .tx_done_o(done));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    ha <= a;
    hwr <= w;
    htr <= HTRANS_NONSEQ;
    do @(posedge clk); while (rdy !== 1'b1);
    htr <= 2'h0;
    hwd <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    d = hrd;
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, d);
  endtask
  // Tick shortened to TCK cycles; start delay 5 ms, drop delay 4 ms below
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    lrst <= 1'b0;
    rc("ctrl", OFF_CTRL, {29'h0, CTRL_RESET});
    rc("status", OFF_STATUS, 32'h1);
    for (int i = 0; i < 7; i++) rc("timer_def", OFF_CTS_DELAY + 4 * i, {16'h0, defs[i]});
    for (int i = 0; i < 7; i++) xfer(1'b1, OFF_CTS_DELAY + 4 * i, i + 2);
    for (int i = 0; i < 7; i++) rc("timer_rw", OFF_CTS_DELAY + 4 * i, i + 2);
    xfer(1'b1, 32'h24, 32'h5a5a);
    rc("unmapped", 32'h24, 32'h0);
    xfer(1'b1, OFF_CTRL, 32'h5);
    req <= 1'b1;
    repeat (30) @(posedge clk);
    chk("const_dcd", 32'h1, dcd);
    chk("const_go", 32'h1, go);
    req <= 1'b0;
    xfer(1'b1, OFF_CTRL, 32'h7);
    repeat (4) @(posedge clk);
    chk("ctl_idle_dcd", 32'h0, dcd);
    req <= 1'b1;
    n = 0;
    while (go !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    req <= 1'b0;
    chk("start_delay", 32'h1, n >= 4 * TCK && n <= 5 * TCK + 12);
    chk("send_dcd", 32'h1, dcd);
    chk("send_busy", 32'h1, busy);
    n = 0;
    while (dcd !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk("drop_delay", 32'h1, n >= 3 * TCK + 12 && n <= 4 * TCK + 24);
    rc("idle_status", OFF_STATUS, 32'h0);
    chk("idle_busy", 32'h0, busy);
    xfer(1'b1, OFF_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk("full_dcd", 32'h1, dcd);
    results();
  end
endmodule
